// *** hdl/precoder_device.sv ***
// Device end: management registers and transmit precoder switching
// Function
// RULE_01 - Management waits 100 ms after power-up
// RULE_02 - Test mode field reads back written value
// RULE_03 - Reset bit self-clears after reset completes
// RULE_04 - Low-power bit writable to zero, reads zero
// RULE_05 - Partner sends continuous zero-payload blocks
// RULE_06 - Header-ok status zero while partner not ok
// RULE_07 - Announce set zero until first request
// RULE_08 - Partner places set id and coefficients
// RULE_09 - Announce requested set in next two blocks
// RULE_10 - First announcing block uses old coefficients
// RULE_11 - Second block precodes with set 1 coefficients
// RULE_12 - Later set 2 request announced twice
// RULE_13 - Set 2 applied from second block on
// RULE_14 - Two status reads fit in one block
// RULE_15 - Coefficients change only at block boundary
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
module precoder_device #(
  parameter int BLOCK_LEN = precoder_pkg::BLOCK_LEN,
  parameter int RESET_CYCLES = precoder_pkg::RESET_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  // Link
  precoder_link_if.device LINK,
  // User payload source
  input wire logic [precoder_pkg::PAYLOAD_W-1:0] TX_DATA_IN,
  input wire logic TX_VALID_IN,
  output logic TX_READY_OUT,
  // Status
  output logic [precoder_pkg::SET_ID_W-1:0] ACTIVE_SET_OUT,
  output logic LOW_POWER_OUT
);
  // ****************************************
  // Management registers
  // ****************************************
  logic soft_reset;
  logic [$clog2(RESET_CYCLES+1)-1:0] reset_count;
  logic low_power;
  logic [2:0] test_mode;
  logic hdr_ok;
  logic [15:0] rdata;
  logic ack;
  logic wr_ctl;
  logic wr_test;
  assign wr_ctl = LINK.mgmt_req && LINK.mgmt_write && LINK.mgmt_mmd == precoder_pkg::MMD_PMA
    && LINK.mgmt_addr == precoder_pkg::REG_PMA_CONTROL_ONE;
  assign wr_test = LINK.mgmt_req && LINK.mgmt_write && LINK.mgmt_mmd == precoder_pkg::MMD_PCS
    && LINK.mgmt_addr == precoder_pkg::REG_PHY_TEST_MODE_CONTROL;
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      soft_reset <= 1'b0;
      reset_count <= '0;
    end
    else if (wr_ctl && LINK.mgmt_wdata[precoder_pkg::CTL_RESET_BIT])
    begin
      soft_reset <= 1'b1;
      reset_count <= '0;
    end
    else if (soft_reset)
    begin
      reset_count <= reset_count + 1'b1;
      if (reset_count == ($bits(reset_count))'(RESET_CYCLES - 1))
      begin
        soft_reset <= 1'b0; // RULE_03
      end
    end
  end
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      low_power <= precoder_pkg::CTL_RESET_VALUE[precoder_pkg::CTL_LOW_POWER_BIT];
      test_mode <= precoder_pkg::TEST_MODE_RESET_VALUE[15:13];
    end
    else
    begin
      if (wr_ctl && !LINK.mgmt_wdata[precoder_pkg::CTL_RESET_BIT])
      begin
        low_power <= LINK.mgmt_wdata[precoder_pkg::CTL_LOW_POWER_BIT]; // RULE_04
      end
      if (wr_test) // RULE_02
      begin
        test_mode <= LINK.mgmt_wdata[precoder_pkg::TEST_MODE_HI:precoder_pkg::TEST_MODE_LO];
      end
    end
  end
  // Reads answer one cycle after request, well inside a block period
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      rdata <= '0;
      ack <= 1'b0;
    end
    else
    begin
      ack <= LINK.mgmt_req && !ack; // RULE_14
      rdata <= '0;
      if (LINK.mgmt_mmd == precoder_pkg::MMD_PMA
        && LINK.mgmt_addr == precoder_pkg::REG_PMA_CONTROL_ONE)
      begin
        rdata[precoder_pkg::CTL_RESET_BIT] <= soft_reset;
        rdata[precoder_pkg::CTL_LOW_POWER_BIT] <= low_power;
      end
      else if (LINK.mgmt_mmd == precoder_pkg::MMD_PCS
        && LINK.mgmt_addr == precoder_pkg::REG_PHY_TEST_MODE_CONTROL)
      begin
        rdata[precoder_pkg::TEST_MODE_HI:precoder_pkg::TEST_MODE_LO] <= test_mode;
      end
      else if (LINK.mgmt_mmd == precoder_pkg::MMD_PCS
        && LINK.mgmt_addr == precoder_pkg::REG_PHY_LINK_STATE_STATUS)
      begin
        rdata[precoder_pkg::STAT_HDR_OK_BIT] <= hdr_ok;
      end
    end
  end
  assign LINK.mgmt_rdata = rdata;
  assign LINK.mgmt_ack = ack;
  assign LOW_POWER_OUT = low_power;
  // ****************************************
  // Received header tracking
  // ****************************************
  logic active;
  logic [precoder_pkg::SET_ID_W-1:0] announce_set;
  logic [precoder_pkg::SET_ID_W-1:0] last_req;
  logic [1:0] announce_left;
  logic pending;
  precoder_pkg::coef_set_t pending_coefs;
  precoder_pkg::coef_set_t active_coefs;
  logic [precoder_pkg::SET_ID_W-1:0] active_set;
  logic block_end;
  logic [$clog2(BLOCK_LEN)-1:0] pos;
  assign active = !soft_reset && !low_power;
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      hdr_ok <= 1'b0;
    end
    else if (!active)
    begin
      hdr_ok <= 1'b0;
    end
    else if (LINK.rx_valid && LINK.rx_start)
    begin
      hdr_ok <= LINK.hdr_received_header_ok; // RULE_06
    end
  end
  // ****************************************
  // Transmit block framing and switching
  // ****************************************
  // Payload source is stalled by the FIFO, and the FIFO by low power or soft reset
  logic [precoder_pkg::PAYLOAD_W-1:0] fifo_data;
  logic fifo_valid;
  sync_fifo #(.WIDTH(precoder_pkg::PAYLOAD_W), .DEPTH(precoder_pkg::FIFO_DEPTH)) sync_fifo_inst (
    .CLOCK_IN(CLOCK_IN),
    .RST_IN(RST_IN),
    .IN_DATA_IN(TX_DATA_IN),
    .IN_VALID_IN(TX_VALID_IN),
    .IN_READY_OUT(TX_READY_OUT),
    .OUT_DATA_OUT(fifo_data),
    .OUT_VALID_OUT(fifo_valid),
    .OUT_READY_IN(active)
  );
  assign block_end = pos == ($bits(pos))'(BLOCK_LEN - 1);
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      pos <= '0;
    end
    else if (!active)
    begin
      pos <= '0;
    end
    else
    begin
      pos <= block_end ? '0 : pos + 1'b1;
    end
  end
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      announce_set <= '0;
      last_req <= '0;
      pending <= 1'b0;
      pending_coefs <= '0;
      announce_left <= '0;
      active_coefs <= '0;
      active_set <= '0;
    end
    else if (!active)
    begin
      announce_set <= '0; // RULE_07
      last_req <= '0;
      pending <= 1'b0;
      announce_left <= '0;
    end
    else
    begin
      if (LINK.rx_valid && LINK.rx_start && hdr_ok
        && LINK.hdr_requested_coef_set != '0 && LINK.hdr_requested_coef_set != last_req)
      begin
        last_req <= LINK.hdr_requested_coef_set; // RULE_09 RULE_12
        pending <= 1'b1;
        pending_coefs <= LINK.hdr_requested_coefs;
      end
      if (block_end)
      begin
        if (pending && announce_left == '0)
        begin
          announce_set <= last_req; // RULE_09 RULE_12
          announce_left <= 2'd2;
        end
        else if (announce_left == 2'd2)
        begin
          active_coefs <= pending_coefs; // RULE_11 RULE_13 RULE_15
          active_set <= announce_set;
          pending <= 1'b0;
          announce_left <= 2'd1;
        end
        else if (announce_left == 2'd1)
        begin
          announce_left <= 2'd0;
        end
      end
    end
  end
  assign ACTIVE_SET_OUT = active_set;
  // Precoding: add the active coefficient indexed by position; first block keeps old set
  logic [precoder_pkg::PAYLOAD_W-1:0] tx_word;
  logic tx_start;
  logic tx_valid;
  logic [precoder_pkg::SET_ID_W-1:0] tx_set;
  logic [precoder_pkg::COEF_W-1:0] cur_coef;
  // Tap wraps every nine words, so a block reuses the set
  assign cur_coef = active_coefs[(32'(pos) % precoder_pkg::COEF_N)*precoder_pkg::COEF_W +:
    precoder_pkg::COEF_W];
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      tx_word <= '0;
      tx_start <= 1'b0;
      tx_valid <= 1'b0;
      tx_set <= '0;
    end
    else
    begin
      tx_valid <= active;
      tx_start <= active && pos == '0;
      tx_set <= announce_set;
      tx_word <= (fifo_valid ? fifo_data : '0) + precoder_pkg::PAYLOAD_W'(cur_coef); // RULE_10
    end
  end
  assign LINK.tx_valid = tx_valid;
  assign LINK.tx_start = tx_start;
  assign LINK.hdr_tx_next_set_id = tx_set;
  assign LINK.tx_payload = tx_word;
endmodule // precoder_device

// *** hdl/precoder_pkg.sv ***
// Shared constants and types for the adaptive precoder switch link
package precoder_pkg;
  // ****************************************
  // Management register map (device side)
  // ****************************************
  localparam logic [4:0] MMD_PMA = 5'h01;
  localparam logic [4:0] MMD_PCS = 5'h03;
  localparam logic [15:0] REG_PMA_CONTROL_ONE = 16'h0000;
  localparam logic [15:0] REG_PHY_TEST_MODE_CONTROL = 16'h0206;
  localparam logic [15:0] REG_PHY_LINK_STATE_STATUS = 16'h0207;
  localparam int CTL_RESET_BIT = 15;
  localparam int CTL_LOW_POWER_BIT = 11;
  localparam int TEST_MODE_HI = 15;
  localparam int TEST_MODE_LO = 13;
  localparam int STAT_HDR_OK_BIT = 10;
  localparam logic [15:0] CTL_RESET_VALUE = 16'h0800;
  localparam logic [15:0] TEST_MODE_RESET_VALUE = 16'h0000;
  // ****************************************
  // Header fields
  // ****************************************
  localparam int SET_ID_W = 2;
  localparam int COEF_W = 8;
  localparam int COEF_N = 9;
  localparam int PAYLOAD_W = 16;
  localparam int BLOCK_LEN = 16;
  localparam int RESET_CYCLES = 16;
  // ****************************************
  // Controller registers (Avalon byte addresses)
  // ****************************************
  localparam logic [7:0] CSR_CMD = 8'h00;
  localparam logic [7:0] CSR_STATUS = 8'h04;
  localparam logic [7:0] CSR_RDATA = 8'h08;
  localparam logic [7:0] CSR_HDR = 8'h0C;
  localparam logic [7:0] CSR_COEF_BASE = 8'h10;
  localparam logic [7:0] CSR_TX_DATA = 8'h40;
  localparam logic [7:0] CSR_RX_DATA = 8'h44;
  localparam int FIFO_DEPTH = 32;
  // Power-up wait before first access
  localparam int POWERUP_MS = 100;
  localparam int CLOCK_MHZ = 100;
  localparam int POWERUP_CYCLES = POWERUP_MS * 1000 * CLOCK_MHZ;
  typedef logic [COEF_N*COEF_W-1:0] coef_set_t;
endpackage

// *** hdl/precoder_link_if.sv ***
// Link between the remote partner end and the precoding device end
interface precoder_link_if;
  // Management access
  logic mgmt_req;
  logic mgmt_write;
  logic [4:0] mgmt_mmd;
  logic [15:0] mgmt_addr;
  logic [15:0] mgmt_wdata;
  logic [15:0] mgmt_rdata;
  logic mgmt_ack;
  // Partner to device blocks
  logic rx_valid;
  logic rx_start;
  logic [1:0] hdr_next_mode;
  logic hdr_received_header_ok;
  logic hdr_receive_link_ok;
  logic [precoder_pkg::SET_ID_W-1:0] hdr_announced_coef_set;
  logic [precoder_pkg::SET_ID_W-1:0] hdr_requested_coef_set;
  precoder_pkg::coef_set_t hdr_requested_coefs;
  logic [precoder_pkg::PAYLOAD_W-1:0] rx_payload;
  // Device to partner blocks
  logic tx_valid;
  logic tx_start;
  logic [precoder_pkg::SET_ID_W-1:0] hdr_tx_next_set_id;
  logic [precoder_pkg::PAYLOAD_W-1:0] tx_payload;
  modport device (
    input mgmt_req, mgmt_write, mgmt_mmd, mgmt_addr, mgmt_wdata,
    output mgmt_rdata, mgmt_ack,
    input rx_valid, rx_start, hdr_next_mode, hdr_received_header_ok, hdr_receive_link_ok,
    input hdr_announced_coef_set, hdr_requested_coef_set, hdr_requested_coefs, rx_payload,
    output tx_valid, tx_start, hdr_tx_next_set_id, tx_payload
  );
  modport partner (
    output mgmt_req, mgmt_write, mgmt_mmd, mgmt_addr, mgmt_wdata,
    input mgmt_rdata, mgmt_ack,
    output rx_valid, rx_start, hdr_next_mode, hdr_received_header_ok, hdr_receive_link_ok,
    output hdr_announced_coef_set, hdr_requested_coef_set, hdr_requested_coefs, rx_payload,
    input tx_valid, tx_start, hdr_tx_next_set_id, tx_payload
  );
endinterface // precoder_link_if

// *** hdl/sync_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  // Fill side
  input wire logic [WIDTH-1:0] IN_DATA_IN,
  input wire logic IN_VALID_IN,
  output logic IN_READY_OUT,
  // Drain side
  output logic [WIDTH-1:0] OUT_DATA_OUT,
  output logic OUT_VALID_OUT,
  input wire logic OUT_READY_IN
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  assign IN_READY_OUT = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign OUT_VALID_OUT = wr_ptr != rd_ptr;
  assign push = IN_VALID_IN && IN_READY_OUT;
  assign pop = OUT_VALID_OUT && OUT_READY_IN;
  assign OUT_DATA_OUT = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge CLOCK_IN)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= IN_DATA_IN;
    end
  end
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // sync_fifo

// *** hdl/precoder_partner.sv ***
// Partner end: block generator and management command master
module precoder_partner #(
  parameter int BLOCK_LEN = precoder_pkg::BLOCK_LEN,
  parameter int POWERUP_CYCLES = precoder_pkg::POWERUP_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  // Link
  precoder_link_if.partner LINK,
  // Avalon-MM slave
  input wire logic [7:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT
);
  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] powerup_count;
  logic ready;
  logic busy;
  logic [15:0] mgmt_rd;
  logic [4:0] hdr_bits;
  logic [precoder_pkg::SET_ID_W-1:0] req_set;
  precoder_pkg::coef_set_t coefs;
  logic [1:0] next_mode;
  logic hit_cmd;
  logic [$clog2(BLOCK_LEN)-1:0] pos;
  logic [precoder_pkg::PAYLOAD_W-1:0] cap_word;
  assign ready = powerup_count == 32'(POWERUP_CYCLES);
  assign hit_cmd = AVS_WRITE_IN && AVS_ADDRESS_IN == precoder_pkg::CSR_CMD;
  // Command writes wait while an access is in flight or before power-up ends
  assign AVS_WAITREQUEST_OUT = hit_cmd && (busy || !ready); // RULE_01
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      powerup_count <= '0;
    end
    else if (!ready)
    begin
      powerup_count <= powerup_count + 1'b1; // RULE_01
    end
  end
  // Command word: [31] write, [20:16] mmd, [15:0] data; address from an earlier write to CSR_RDATA
  logic [15:0] cmd_addr;
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      busy <= 1'b0;
      mgmt_rd <= '0;
      cmd_addr <= '0;
      hdr_bits <= '0;
      req_set <= '0;
      coefs <= '0;
      next_mode <= '0;
    end
    else
    begin
      if (hit_cmd && !busy && ready)
      begin
        busy <= 1'b1;
      end
      else if (busy && LINK.mgmt_ack)
      begin
        busy <= 1'b0;
        mgmt_rd <= LINK.mgmt_rdata; // RULE_14
      end
      if (AVS_WRITE_IN && AVS_ADDRESS_IN == precoder_pkg::CSR_RDATA)
      begin
        cmd_addr <= AVS_WRITEDATA_IN[15:0];
      end
      if (AVS_WRITE_IN && AVS_ADDRESS_IN == precoder_pkg::CSR_HDR)
      begin
        next_mode <= AVS_WRITEDATA_IN[1:0]; // RULE_05
        hdr_bits <= AVS_WRITEDATA_IN[6:2];
        req_set <= AVS_WRITEDATA_IN[8:7]; // RULE_08
      end
      for (int i = 0; i < precoder_pkg::COEF_N; i++)
      begin
        if (AVS_WRITE_IN && AVS_ADDRESS_IN == precoder_pkg::CSR_COEF_BASE + 8'(4 * i))
        begin
          coefs[i*precoder_pkg::COEF_W +: precoder_pkg::COEF_W] <= AVS_WRITEDATA_IN[7:0];
        end
      end
    end
  end
  logic [31:0] cmd_word;
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      cmd_word <= '0;
    end
    else if (hit_cmd && !busy && ready)
    begin
      cmd_word <= AVS_WRITEDATA_IN;
    end
  end
  assign LINK.mgmt_req = busy && !LINK.mgmt_ack;
  assign LINK.mgmt_write = cmd_word[31];
  assign LINK.mgmt_mmd = cmd_word[20:16];
  assign LINK.mgmt_addr = cmd_addr;
  assign LINK.mgmt_wdata = cmd_word[15:0];
  // ****************************************
  // Block generator: continuous zero payload
  // ****************************************
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      pos <= '0;
    end
    else
    begin
      pos <= pos == ($bits(pos))'(BLOCK_LEN - 1) ? '0 : pos + 1'b1; // RULE_05
    end
  end
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      cap_word <= '0;
    end
    else if (LINK.tx_valid)
    begin
      cap_word <= LINK.tx_payload;
    end
  end
  assign LINK.rx_valid = 1'b1;
  assign LINK.rx_start = pos == '0;
  assign LINK.hdr_next_mode = next_mode;
  assign LINK.hdr_received_header_ok = hdr_bits[0];
  assign LINK.hdr_receive_link_ok = hdr_bits[1];
  assign LINK.hdr_announced_coef_set = hdr_bits[3:2];
  assign LINK.hdr_requested_coef_set = req_set;
  assign LINK.hdr_requested_coefs = coefs;
  assign LINK.rx_payload = '0;
  always_comb
  begin
    AVS_READDATA_OUT = '0;
    if (AVS_READ_IN)
    begin
      unique case (AVS_ADDRESS_IN)
        precoder_pkg::CSR_STATUS: AVS_READDATA_OUT = {29'h0, ready, busy, 1'b0};
        precoder_pkg::CSR_RDATA: AVS_READDATA_OUT = {16'h0, mgmt_rd};
        precoder_pkg::CSR_RX_DATA: AVS_READDATA_OUT = {14'h0, LINK.hdr_tx_next_set_id, cap_word};
        default: AVS_READDATA_OUT = '0;
      endcase
    end
  end
endmodule // precoder_partner

// *** verif/precoder_link_asserts.sv ***
// Concurrent checks on the link between partner end and device end
module precoder_link_asserts (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  // Management
  input wire logic mgmt_req,
  input wire logic mgmt_write,
  input wire logic [15:0] mgmt_addr,
  input wire logic mgmt_ack,
  // Blocks
  input wire logic rx_valid,
  input wire logic rx_start,
  input wire logic [precoder_pkg::SET_ID_W-1:0] hdr_requested_coef_set,
  input wire logic tx_start,
  input wire logic [precoder_pkg::SET_ID_W-1:0] hdr_tx_next_set_id
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  logic seen_req;
  // Monotone flag: once any set is asked for, zero is no longer forced
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      seen_req <= 1'b0;
    else if (rx_start && hdr_requested_coef_set != '0)
      seen_req <= 1'b1;
  end
  sequence mgmt_taken;
    mgmt_req && !mgmt_ack;
  endsequence
  sequence mgmt_answer;
    ##1 mgmt_ack;
  endsequence
  mgmt_answer_a: assert property (mgmt_taken |-> mgmt_answer)
    else $error("management request not answered in one cycle");
  ack_pulse_a: assert property (mgmt_ack |=> !mgmt_ack)
    else $error("management acknowledge longer than one cycle");
  req_hold_a: assert property (mgmt_taken |=> $stable(mgmt_addr) && $stable(mgmt_write))
    else $error("management request changed before acknowledge");
  ack_cause_a: assert property ($rose(mgmt_ack) |-> $past(mgmt_req))
    else $error("acknowledge without request");
  set_zero_a: assert property (!seen_req |-> hdr_tx_next_set_id == '0)
    else $error("nonzero set announced before any request");
  set_boundary_a: assert property ($changed(hdr_tx_next_set_id) |-> tx_start)
    else $error("announced set changed inside a block");
  sequence set_held;
    $stable(hdr_tx_next_set_id) [*8];
  endsequence
  set_hold_a: assert property ($changed(hdr_tx_next_set_id) |=> set_held)
    else $error("announced set not held through its block");
  tx_spacing_a: assert property (tx_start |=> (!tx_start) [*8])
    else $error("transmit blocks too short");
  rx_spacing_a: assert property (rx_start |=> (!rx_start) [*8])
    else $error("partner blocks too short");
  rx_stream_a: assert property (rx_valid)
    else $error("partner block stream interrupted");
endmodule // precoder_link_asserts

// *** verif/test_adaptive_precoder_tx_switch.sv ***
// Self-checking testbench for both link ends
module test_adaptive_precoder_tx_switch;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK_IN = 1'b0;
  logic RST_IN = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic tx_valid_in = 1'b0;
  logic tx_ready;
  logic low_power;
  logic [1:0] active_set;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;
  precoder_link_if link();
  precoder_device #(.BLOCK_LEN(16), .RESET_CYCLES(16)) precoder_device_inst (
    .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .LINK(link), .TX_DATA_IN(16'h0000),
    .TX_VALID_IN(tx_valid_in), .TX_READY_OUT(tx_ready), .ACTIVE_SET_OUT(active_set),
    .LOW_POWER_OUT(low_power));
  // Short power-up wait keeps the run small
  precoder_partner #(.BLOCK_LEN(16), .POWERUP_CYCLES(100)) precoder_partner_inst (
    .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .LINK(link), .AVS_ADDRESS_IN(avs_address),
    .AVS_READ_IN(avs_read), .AVS_WRITE_IN(avs_write), .AVS_WRITEDATA_IN(avs_writedata),
    .AVS_READDATA_OUT(avs_readdata), .AVS_WAITREQUEST_OUT(avs_waitrequest));
  precoder_link_asserts precoder_link_asserts_inst (
    .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .mgmt_req(link.mgmt_req),
    .mgmt_write(link.mgmt_write), .mgmt_addr(link.mgmt_addr), .mgmt_ack(link.mgmt_ack),
    .rx_valid(link.rx_valid), .rx_start(link.rx_start),
    .hdr_requested_coef_set(link.hdr_requested_coef_set), .tx_start(link.tx_start),
    .hdr_tx_next_set_id(link.hdr_tx_next_set_id));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic give_verdict();
    $display("Compares %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic av_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    @(posedge CLOCK_IN);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge CLOCK_IN);
    while (avs_waitrequest !== 1'b0) @(posedge CLOCK_IN);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic mgmt(input logic wr, input logic [4:0] mmd, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    logic [31:0] r;
    av_xfer(1'b1, precoder_pkg::CSR_RDATA, {16'h0000, a}, r);
    av_xfer(1'b1, precoder_pkg::CSR_CMD, {wr, 10'h000, mmd, d}, r);
    r = 32'h00000002;
    while (r[1] !== 1'b0) av_xfer(1'b0, precoder_pkg::CSR_STATUS, 32'h0, r);
    av_xfer(1'b0, precoder_pkg::CSR_RDATA, 32'h0, r);
    q = r[15:0];
  endtask
  task automatic set_hdr(input logic ok, input logic [1:0] set);
    logic [31:0] r;
    av_xfer(1'b1, precoder_pkg::CSR_HDR, {23'h0, set, 4'h0, ok, 2'b00}, r);
  endtask
  task automatic wait_blocks(input int n);
    repeat (n)
    begin
      @(posedge CLOCK_IN);
      while (link.tx_start !== 1'b1) @(posedge CLOCK_IN);
    end
  endtask
  // One whole block from its first word; zero base means no precoding yet
  task automatic chk_blk(input logic [1:0] set, input logic [7:0] base);
    for (int w = 0; w < 16; w++)
    begin
      chk(link.tx_start, w == 0);
      if (w == 0) chk(link.hdr_tx_next_set_id, set);
      chk(link.tx_payload, (base == 8'h00) ? 16'h0000 : {8'h00, base + 8'(w % 9)});
      @(posedge CLOCK_IN);
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_powerup();
    logic [31:0] r;
    logic [15:0] q;
    av_xfer(1'b0, precoder_pkg::CSR_STATUS, 32'h0, r);
    chk(r[2], 1'b0);
    mgmt(1'b0, precoder_pkg::MMD_PMA, precoder_pkg::REG_PMA_CONTROL_ONE, 16'h0000, q);
    chk(cycles > 108, 1'b1);
    chk(q, precoder_pkg::CTL_RESET_VALUE);
    $display("t_powerup done");
  endtask
  // Low power stops the drain, so the buffer must fill and refuse
  task automatic t_fifo();
    int cnt;
    cnt = 0;
    @(posedge CLOCK_IN);
    tx_valid_in <= 1'b1;
    @(posedge CLOCK_IN);
    while (tx_ready === 1'b1 && cnt < 64)
    begin
      cnt++;
      @(posedge CLOCK_IN);
    end
    tx_valid_in <= 1'b0;
    chk(cnt, precoder_pkg::FIFO_DEPTH);
    $display("t_fifo done");
  endtask
  task automatic t_regs();
    logic [15:0] q;
    int k;
    mgmt(1'b1, precoder_pkg::MMD_PCS, precoder_pkg::REG_PHY_TEST_MODE_CONTROL, 16'h2000, q);
    mgmt(1'b0, precoder_pkg::MMD_PCS, precoder_pkg::REG_PHY_TEST_MODE_CONTROL, 16'h0000, q);
    chk(q[15:13], 3'b001);
    mgmt(1'b1, precoder_pkg::MMD_PMA, precoder_pkg::REG_PMA_CONTROL_ONE, 16'h8800, q);
    k = 0;
    do
    begin
      mgmt(1'b0, precoder_pkg::MMD_PMA, precoder_pkg::REG_PMA_CONTROL_ONE, 16'h0000, q);
      k++;
    end
    while (q[15] !== 1'b0 && k < 40);
    chk(q[15], 1'b0);
    chk({q[11], low_power}, 2'b11);
    mgmt(1'b1, precoder_pkg::MMD_PMA, precoder_pkg::REG_PMA_CONTROL_ONE, 16'h0000, q);
    mgmt(1'b0, precoder_pkg::MMD_PMA, precoder_pkg::REG_PMA_CONTROL_ONE, 16'h0000, q);
    chk({q[11], low_power}, 2'b00);
    mgmt(1'b0, precoder_pkg::MMD_PCS, 16'h0100, 16'h0000, q);
    chk(q, 16'h0000);
    wait_blocks(4);
    chk(tx_ready, 1'b1);
    $display("t_regs done");
  endtask
  task automatic t_hdr();
    logic [15:0] q;
    set_hdr(1'b0, 2'd0);
    wait_blocks(3);
    mgmt(1'b0, precoder_pkg::MMD_PCS, precoder_pkg::REG_PHY_LINK_STATE_STATUS, 16'h0, q);
    chk(q[10], 1'b0);
    chk(link.hdr_tx_next_set_id, 2'd0);
    set_hdr(1'b1, 2'd0);
    wait_blocks(3);
    mgmt(1'b0, precoder_pkg::MMD_PCS, precoder_pkg::REG_PHY_LINK_STATE_STATUS, 16'h0, q);
    chk(q[10], 1'b1);
    $display("t_hdr done");
  endtask
  task automatic t_switch(input logic [1:0] set, input logic [7:0] old_b, input logic [7:0] new_b);
    logic [31:0] r;
    int k;
    for (int i = 0; i < 9; i++)
      av_xfer(1'b1, precoder_pkg::CSR_COEF_BASE + 8'(4 * i), {24'h0, new_b + 8'(i)}, r);
    set_hdr(1'b1, set);
    k = 0;
    do
    begin
      wait_blocks(1);
      k++;
    end
    while (link.hdr_tx_next_set_id !== set && k < 8);
    chk(active_set, set - 2'd1);
    chk_blk(set, old_b);
    chk_blk(set, new_b);
    chk(active_set, set);
    av_xfer(1'b0, precoder_pkg::CSR_RX_DATA, 32'h0, r);
    chk(r[17:16], set);
    $display("t_switch set %0d done", set);
  endtask
  // ****************************************
  // Clock, watchdog, main sequence
  // ****************************************
  initial
  begin
    forever #5 CLOCK_IN = ~CLOCK_IN;
  end
  always @(posedge CLOCK_IN)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (8) @(posedge CLOCK_IN);
    RST_IN <= 1'b0;
    t_powerup();
    t_fifo();
    t_regs();
    t_hdr();
    t_switch(2'd1, 8'h00, 8'h11);
    t_switch(2'd2, 8'h11, 8'h31);
    give_verdict();
  end
endmodule // test_adaptive_precoder_tx_switch
